// *** core/swm_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host end: sends one eight-bit frame per command and returns the status byte.
module swm_host #(
	parameter int unsigned WAKE_CYC    = swm_pkg::WAKE_CYC,
	parameter int unsigned HALF_CYC    = swm_pkg::HALF_CYC,
	parameter int unsigned CS_HIGH_CYC = swm_pkg::CS_HIGH_CYC
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	swm_link_if.host        link,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic [7:0] cmd_i,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_o
);

	// All state of the host end in one record.
	typedef struct packed {
		swm_pkg::swm_hstate_t st;     // Sequencer state.
		logic [15:0]          cnt;    // Phase counter.
		logic [3:0]           nbit;   // Bits sent.
		logic [7:0]           tx;     // Outgoing frame.
		logic [7:0]           rx;     // Incoming status.
		logic [1:0]           miso_s; // Data input sync pair.
		logic                 cs_n;   // Chip select drive.
		logic                 sclk;   // Serial clock drive.
		logic                 mosi;   // Data drive.
		logic                 rsp_v;  // Response strobe.
		logic [7:0]           rsp;    // Response byte.
	} swm_host_t;

	swm_host_t q; // Registered state.
	swm_host_t d; // Next state.

	// Frame sequencer.
	always_comb begin
		d        = q;
		d.miso_s = {q.miso_s[0], link.miso_line};
		d.rsp_v  = 1'b0;
		d.cnt    = q.cnt + 16'h0001;
		case (q.st)
			swm_pkg::HS_IDLE: begin
				d.cnt = 16'h0000;
				if (cmd_valid_i) begin
					d.tx   = cmd_i;
					if (cmd_i[swm_pkg::CMD_MSB:swm_pkg::CMD_LSB] == swm_pkg::CMD_WRITE &&
						!cmd_i[swm_pkg::WAKE_HOLD_POS]) begin
						d.tx[swm_pkg::OUTS_MSB:swm_pkg::OUTS_LSB] = '0;
					end
					d.cs_n = 1'b0;
					d.st   = swm_pkg::HS_WAKE;
				end
			end
			swm_pkg::HS_WAKE: begin
				if (q.cnt == 16'(WAKE_CYC - 1)) begin
					d.cnt  = 16'h0000;
					d.nbit = 4'h0;
					d.mosi = q.tx[7];
					d.st   = swm_pkg::HS_SHIFT;
				end
			end
			swm_pkg::HS_SHIFT: begin
				// Each half period toggles the clock; the device samples on the rise.
				if (q.cnt == 16'(HALF_CYC - 1)) begin
					d.cnt = 16'h0000;
					if (!q.sclk) begin
						d.sclk = 1'b1;
					end else begin
						// Sample just before the fall, when the device bit has long settled.
						d.rx   = {q.rx[6:0], q.miso_s[1]};
						d.sclk = 1'b0;
						d.tx   = {q.tx[6:0], 1'b0};
						d.mosi = q.tx[6];
						d.nbit = q.nbit + 4'h1;
						if (q.nbit == 4'(swm_pkg::FRAME_BITS - 1)) begin
							d.mosi = 1'b0;
							d.st   = swm_pkg::HS_END;
						end
					end
				end
			end
			swm_pkg::HS_END: begin
				if (q.cnt == 16'(HALF_CYC - 1)) begin
					d.cnt  = 16'h0000;
					d.cs_n = 1'b1;
					d.st   = swm_pkg::HS_GAP;
				end
			end
			swm_pkg::HS_GAP: begin
				// Keep chip select high long enough before the next frame.
				if (q.cnt == 16'(CS_HIGH_CYC - 1)) begin
					d.rsp_v = 1'b1;
					d.rsp   = q.rx;
					d.st    = swm_pkg::HS_IDLE;
				end
			end
			default: begin
				d.st = swm_pkg::HS_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q      <= '0;
			q.st   <= swm_pkg::HS_IDLE;
			q.cs_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs.
	always_comb begin
		link.chip_select_n = q.cs_n;
		link.sclk          = q.sclk;
		link.mosi          = q.mosi;
		cmd_ready_o        = (q.st == swm_pkg::HS_IDLE);
		rsp_valid_o        = q.rsp_v;
		rsp_o              = q.rsp;
	end

endmodule
`default_nettype wire

// *** core/swm_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Serial link between host and device.
interface swm_link_if;
	logic chip_select_n; // Chip select, low during a frame.
	logic sclk;          // Serial clock from the host.
	logic mosi;          // Host to device data.
	logic miso;          // Device data output.
	logic miso_oe;       // Device drives its data output.
	logic miso_line;     // Resolved data line; a weak pull-down holds it low when idle.

	// The wire is resolved here so the design files never see a floating level.
	assign miso_line = miso_oe ? miso : 1'b0;

	modport dev (
		input  chip_select_n,
		input  sclk,
		input  mosi,
		output miso,
		output miso_oe
	);

	modport host (
		output chip_select_n,
		output sclk,
		output mosi,
		input  miso_line
	);
endinterface
`default_nettype wire

// *** core/swm_mode_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Start in standby, analogue off, drivers off.
// - Chip select falling in standby wakes device.
// - Host waits 10 us before first transfer.
// - Writing wake hold one keeps device active.
// - Unheld device sleeps 256 us, clearing data.
// - Host turns outputs off before standby.
// - Pump disabled in standby and thermal shutdown.
// - Filtered pump low kills drivers, latches flag.
// - Only software reset clears flag, drivers.
// - State survives power supply glitches.
// - Drivers enable 250-410 us after select rises.
module swm_mode_ctrl #(
	parameter int unsigned AWAKE_CYC     = swm_pkg::AWAKE_CYC,
	parameter int unsigned SET_CYC       = swm_pkg::SET_CYC,
	parameter int unsigned PUMP_FILT_CYC = swm_pkg::PUMP_FILT_CYC
) (
	input  wire logic                      sys_clk_i,
	input  wire logic                      rstn_i,
	swm_link_if.dev                        link,
	input  wire logic                      pump_low_i,
	input  wire logic                      therm_sd_i,
	output logic                           analog_en_o,
	output logic                           pump_en_o,
	output logic                           drv_en_o,
	output logic                           gate_rlow_o,
	output logic [swm_pkg::OUTS_W-1:0]     outs_o,
	output logic                           active_o,
	output logic                           pump_undervolt_flag_o
);

	// All state of the device end in one record.
	typedef struct packed {
		swm_pkg::swm_dstate_t       st;      // Mode state.
		logic [2:0]                 cs_s;    // Chip select sync pair plus previous value.
		logic [2:0]                 sclk_s;  // Serial clock sync pair plus previous value.
		logic [1:0]                 mosi_s;  // Data input sync pair.
		logic [1:0]                 pl_s;    // Pump low sync pair.
		logic [1:0]                 th_s;    // Thermal shutdown sync pair.
		logic [7:0]                 rx;      // Receive shift register.
		logic [7:0]                 tx;      // Transmit shift register.
		logic [3:0]                 nbit;    // Bits taken in this frame.
		logic [15:0]                tmr;     // Time since chip select rose.
		logic [15:0]                filt;    // Pump low filter count.
		logic                       hold;    // Latched wake hold bit.
		logic [swm_pkg::OUTS_W-1:0] outs;    // Latched output controls.
		logic                       drv_on;  // Driver enable delay has elapsed.
		logic                       flag;    // Latched pump undervoltage flag.
	} swm_dev_t;

	swm_dev_t q; // Registered state.
	swm_dev_t d; // Next state.

	// Synchronised views and edges; first synchroniser flops are never read.
	logic cs_n;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic therm;
	logic pump_en;
	logic drv_ok;
	logic [7:0] status;

	// Pin decode; nothing here looks at a first synchroniser flop.
	always_comb begin
		cs_n      = q.cs_s[1];
		cs_fall   = q.cs_s[2] & ~q.cs_s[1];
		cs_rise   = ~q.cs_s[2] & q.cs_s[1];
		sclk_rise = ~q.sclk_s[2] & q.sclk_s[1];
		sclk_fall = q.sclk_s[2] & ~q.sclk_s[1];
		therm     = q.th_s[1];
		pump_en   = (q.st != swm_pkg::DS_STANDBY) & ~therm;
		drv_ok    = q.drv_on & ~q.flag & ~therm;
		status    = swm_pkg::BYTE_RST;
		status[swm_pkg::ST_PUMP_FLAG_POS] = q.flag;
		status[swm_pkg::ST_ACTIVE_POS]    = (q.st == swm_pkg::DS_ACTIVE);
		status[swm_pkg::ST_DRV_POS]       = drv_ok;
	end

	// Next-state logic for synchronisers, serial shifting, mode and fault.
	always_comb begin
		d        = q;
		d.cs_s   = {q.cs_s[1], q.cs_s[0], link.chip_select_n};
		d.sclk_s = {q.sclk_s[1], q.sclk_s[0], link.sclk};
		d.mosi_s = {q.mosi_s[0], link.mosi};
		d.pl_s   = {q.pl_s[0], pump_low_i};
		d.th_s   = {q.th_s[0], therm_sd_i};

		// The timer runs only with chip select high, so a frame pauses the fall-back.
		if (cs_n && q.tmr != 16'hFFFF) begin
			d.tmr = q.tmr + 16'h0001;
		end

		// A frame begins: load status so its first bit is out before the first clock.
		if (cs_fall) begin
			d.tx   = status;
			d.nbit = 4'h0;
			if (q.st == swm_pkg::DS_STANDBY) begin
				d.st = swm_pkg::DS_AWAKE;
			end
		end

		// Shifting happens only inside a frame.
		if (!cs_n) begin
			if (sclk_rise) begin
				d.rx = {q.rx[6:0], q.mosi_s[1]};
				if (q.nbit != 4'hF) begin
					d.nbit = q.nbit + 4'h1;
				end
			end
			if (sclk_fall) begin
				d.tx = {q.tx[6:0], 1'b0};
			end
		end

		// A frame ends: decode only complete frames; a short or long one is dropped.
		if (cs_rise) begin
			d.tmr = 16'h0000;
			if (q.nbit == 4'(swm_pkg::FRAME_BITS)) begin
				case (q.rx[swm_pkg::CMD_MSB:swm_pkg::CMD_LSB])
					swm_pkg::CMD_WRITE: begin
						d.hold = q.rx[swm_pkg::WAKE_HOLD_POS];
						d.outs = q.rx[swm_pkg::OUTS_MSB:swm_pkg::OUTS_LSB];
					end
					swm_pkg::CMD_SRST: begin
						d.flag = 1'b0;
					end
					default: begin
						// Reads change nothing.
					end
				endcase
			end
			if (q.st != swm_pkg::DS_STANDBY) begin
				if (d.hold) begin
					d.st = swm_pkg::DS_ACTIVE;
				end else begin
					d.st     = swm_pkg::DS_AWAKE;
					d.drv_on = 1'b0;
				end
			end
		end

		// Mode timing after chip select has risen.
		case (q.st)
			swm_pkg::DS_STANDBY: begin
				d.drv_on = 1'b0;
			end
			swm_pkg::DS_AWAKE: begin
				if (cs_n && !cs_rise && q.tmr == 16'(AWAKE_CYC - 1)) begin
					d.st     = swm_pkg::DS_STANDBY;
					d.hold   = 1'b0;
					d.outs   = '0;
					d.rx     = swm_pkg::BYTE_RST;
					d.tx     = swm_pkg::BYTE_RST;
					d.nbit   = 4'h0;
					d.drv_on = 1'b0;
				end
			end
			swm_pkg::DS_ACTIVE: begin
				if (cs_n && !cs_rise && q.tmr == 16'(SET_CYC - 1)) begin
					d.drv_on = 1'b1;
				end
			end
			default: begin
				d.st = swm_pkg::DS_STANDBY;
			end
		endcase

		if (pump_en && q.pl_s[1]) begin
			if (q.filt == 16'(PUMP_FILT_CYC - 1)) begin
				// Set wins over a software reset in the same cycle.
				d.flag = 1'b1;
			end else begin
				d.filt = q.filt + 16'h0001;
			end
		end else begin
			d.filt = 16'h0000;
		end
	end

	// State register. Only the logic-supply reset clears it, so power-driver
	// supply glitches leave control and status untouched.
	// Logic-supply state.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q        <= '0;
			q.st     <= swm_pkg::DS_STANDBY;
			q.cs_s   <= 3'h7;
			q.rx     <= swm_pkg::BYTE_RST;
			q.tx     <= swm_pkg::BYTE_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs; the data line is driven only inside a frame.
	always_comb begin
		link.miso             = q.tx[7];
		link.miso_oe          = ~cs_n;
		analog_en_o           = (q.st != swm_pkg::DS_STANDBY);
		pump_en_o             = pump_en;
		drv_en_o              = drv_ok;
		gate_rlow_o           = ~drv_ok;
		outs_o                = drv_ok ? q.outs : '0;
		active_o              = (q.st == swm_pkg::DS_ACTIVE);
		pump_undervolt_flag_o = q.flag;
	end

endmodule
`default_nettype wire

// *** core/swm_pkg.sv ***
// Shared constants and types for the standby/wake mode controller and its host.
package swm_pkg;

	// System clock period in nanoseconds (40 MHz).
	localparam int unsigned CLK_PERIOD_NS = 25;

	// Wake-up settle time the host waits after pulling chip select low, in microseconds.
	localparam int unsigned T_WAKE_US = 10;
	// Least time; rounds up to whole cycles.
	localparam int unsigned WAKE_CYC = (T_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Stay-awake time before an unheld device falls back to standby, in microseconds.
	localparam int unsigned T_AWAKE_US = 256;
	// Typical figure; rounds down.
	localparam int unsigned AWAKE_CYC = (T_AWAKE_US * 1000) / CLK_PERIOD_NS;

	// Driver enable delay window after chip select rises, in microseconds.
	localparam int unsigned T_SET_MIN_US = 250;
	localparam int unsigned T_SET_TYP_US = 310;
	localparam int unsigned T_SET_MAX_US = 410;
	// The design aims at the typical figure, well inside the window.
	localparam int unsigned SET_CYC = (T_SET_TYP_US * 1000) / CLK_PERIOD_NS;

	// Charge-pump low filter time, in microseconds.
	localparam int unsigned T_PUMP_FILT_US = 64;
	localparam int unsigned PUMP_FILT_CYC =
		(T_PUMP_FILT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial clock period and least chip select high time, in nanoseconds.
	localparam int unsigned T_SCLK_NS = 1000;
	localparam int unsigned T_CS_HIGH_NS = 4000;
	// Half a serial clock period; least time, rounds up.
	localparam int unsigned HALF_CYC = (T_SCLK_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CS_HIGH_CYC = (T_CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial frame layout: eight bits, most significant first.
	localparam int unsigned FRAME_BITS = 8;
	localparam int unsigned CMD_MSB = 7;
	localparam int unsigned CMD_LSB = 6;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_SRST = 2'h2;
	// Write frame: bit 0 is the wake hold bit, bits 5..1 the output controls, bits 7..6 the command.
	localparam int unsigned WAKE_HOLD_POS = 0;
	localparam int unsigned OUTS_LSB = 1;
	localparam int unsigned OUTS_MSB = 5;
	localparam int unsigned OUTS_W = OUTS_MSB - OUTS_LSB + 1;

	// Status byte returned on every frame.
	localparam int unsigned ST_PUMP_FLAG_POS = 0;
	localparam int unsigned ST_ACTIVE_POS = 1;
	localparam int unsigned ST_DRV_POS = 2;

	// Reset values.
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Device mode states.
	typedef enum logic [1:0] {
		DS_STANDBY,
		DS_AWAKE,
		DS_ACTIVE
	} swm_dstate_t;

	// Host sequencer states.
	typedef enum logic [2:0] {
		HS_IDLE,
		HS_WAKE,
		HS_SHIFT,
		HS_END,
		HS_GAP
	} swm_hstate_t;

endpackage

// *** dv/swm_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the mode controller outputs and the link wires.
module swm_chk_sva #(
	parameter int unsigned WAKE_CYC  = swm_pkg::WAKE_CYC,
	parameter int unsigned AWAKE_CYC = swm_pkg::AWAKE_CYC,
	parameter int unsigned SET_CYC   = swm_pkg::SET_CYC
) (
	input wire logic                       sys_clk_i,
	input wire logic                       rstn_i,
	input wire logic                       chip_select_n,
	input wire logic                       sclk,
	input wire logic                       therm_sd_i,
	input wire logic                       analog_en_o,
	input wire logic                       pump_en_o,
	input wire logic                       drv_en_o,
	input wire logic                       gate_rlow_o,
	input wire logic [swm_pkg::OUTS_W-1:0] outs_o,
	input wire logic                       active_o,
	input wire logic                       pump_undervolt_flag_o
);
	logic [15:0] act_cnt_q; // Cycles spent in active mode.
	logic [15:0] csh_cnt_q; // Cycles with chip select high.
	logic [15:0] csl_cnt_q; // Cycles with chip select low, so the wake wait can be measured.

	// Saturating counters; they only give lower bounds on elapsed time.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_cnt_q <= 16'h0000;
			csh_cnt_q <= 16'h0000;
			csl_cnt_q <= 16'h0000;
		end else begin
			act_cnt_q <= active_o ? act_cnt_q + {15'h0000, act_cnt_q != 16'hFFFF} : 16'h0000;
			csh_cnt_q <= chip_select_n ? csh_cnt_q + {15'h0000, csh_cnt_q != 16'hFFFF} : 16'h0000;
			csl_cnt_q <= ~chip_select_n ? csl_cnt_q + {15'h0000, csl_cnt_q != 16'hFFFF} : 16'h0000;
		end
	end

	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	AST_STBY_OFF: assert property (!analog_en_o |-> !pump_en_o && !drv_en_o) // standby quiet
		else $error("Pump or drivers on in standby.");
	AST_WAKE: assert property ($fell(chip_select_n) && !analog_en_o // wake
		|-> ##[1:8] analog_en_o)
		else $error("Select fall did not wake the device.");
	// The first clock must come after the whole wake wait, not merely after half a bit.
	AST_WAKE_GAP: assert property ($rose(sclk) |-> csl_cnt_q >= WAKE_CYC) // host waits
		else $error("Serial clock too soon after select fall.");
	AST_ACT_AWAKE: assert property (active_o |-> analog_en_o) // active awake
		else $error("Active mode without analogue section.");
	AST_FALLBACK: assert property (csh_cnt_q > AWAKE_CYC + 8 && !active_o // fall back
		|-> !analog_en_o)
		else $error("Unheld device stayed awake too long.");
	AST_THERM: assert property (therm_sd_i [*4] |-> !pump_en_o && !drv_en_o) // therm off
		else $error("Pump or drivers on in thermal shutdown.");
	AST_FLAG_OFF: assert property (pump_undervolt_flag_o // fault off
		|-> !drv_en_o && outs_o == '0)
		else $error("Drivers on while pump fault latched.");
	AST_GATE_LOW: assert property (gate_rlow_o == !drv_en_o) // gates low
		else $error("Gate pull-low does not mirror driver enable.");
	AST_FLAG_CLR: assert property ($fell(pump_undervolt_flag_o) // reset frame
		|-> !$past(chip_select_n, 6))
		else $error("Pump fault flag cleared without a frame.");
	AST_DRV_DELAY: assert property (drv_en_o // enable delay
		|-> active_o && act_cnt_q >= SET_CYC - 8)
		else $error("Drivers enabled too early after activation.");
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
// Drives the host command port and watches the device end.
module tb;
	localparam int unsigned WKC = 40;  // Shortened host wake wait; longer than half a bit on purpose.
	localparam int unsigned AWK = 200; // Shortened stay-awake count.
	localparam int unsigned SET = 300; // Shortened driver delay count.
	localparam int unsigned FLT = 20;  // Shortened pump filter count.
	logic       sys_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       pump_low = 1'b0;
	logic       therm = 1'b0;
	logic       cmd_valid = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp;
	logic       analog_en;
	logic       pump_en;
	logic       drv_en;
	logic       gate_rlow;
	logic [4:0] outs;
	logic       active;
	logic       flag;
	int         failures = 0;
	int         total_checks = 0;

	swm_link_if link ();
	swm_host #(.WAKE_CYC(WKC), .HALF_CYC(20), .CS_HIGH_CYC(10)) i_swm_host (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .link(link), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_i(cmd), .rsp_valid_o(rsp_valid), .rsp_o(rsp));
	swm_mode_ctrl #(.AWAKE_CYC(AWK), .SET_CYC(SET), .PUMP_FILT_CYC(FLT)) i_swm_mode_ctrl (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .link(link), .pump_low_i(pump_low),
		.therm_sd_i(therm), .analog_en_o(analog_en), .pump_en_o(pump_en), .drv_en_o(drv_en),
		.gate_rlow_o(gate_rlow), .outs_o(outs), .active_o(active), .pump_undervolt_flag_o(flag));
	swm_chk_sva #(.WAKE_CYC(WKC), .AWAKE_CYC(AWK), .SET_CYC(SET)) i_swm_chk_sva (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .chip_select_n(link.chip_select_n),
		.sclk(link.sclk), .therm_sd_i(therm), .analog_en_o(analog_en), .pump_en_o(pump_en),
		.drv_en_o(drv_en), .gate_rlow_o(gate_rlow), .outs_o(outs), .active_o(active),
		.pump_undervolt_flag_o(flag));

	// Free-running system clock at 40 MHz.
	always #12.5 sys_clk = ~sys_clk;

	// Prints the verdict and ends the run.
	task automatic test_done();
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Waits a number of falling edges, where inputs change.
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// Sends one frame through the host and returns the status byte.
	task automatic xfer(input logic [7:0] c, output logic [7:0] st);
		int n;
		n = 0;
		// Ready is stable at the falling edge, so the next rising edge takes it.
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		cmd = c;
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		st = rsp;
		// A host that never answers counts as a mismatch.
		if (n >= 3000) begin
			failures++;
			test_done();
		end
	endtask

	// Main sequence of frames and expected outcomes.
	initial begin
		logic [7:0] st;
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		tick(2);
		`CHK({analog_en, pump_en, drv_en, gate_rlow, outs}, 9'h020) // quiet start
		xfer(8'h00, st); // read wakes the device
		`CHK(st, 8'h00) // standby status
		`CHK({analog_en, active}, 2'b10) // woken
		tick(AWK - 40);
		`CHK(analog_en, 1'b1) // still awake
		tick(60);
		`CHK(analog_en, 1'b0) // fell back
		// Hold bit set with a pattern on the output controls.
		xfer(8'h6B, st); // write with hold set
		`CHK({active, drv_en}, 2'b10) // active
		tick(SET * 250 / 310 - 12);
		`CHK(drv_en, 1'b0) // not before window
		tick(SET * 410 / 310 - SET * 250 / 310);
		`CHK({drv_en, outs}, 6'h35) // enabled with latched controls
		xfer(8'h00, st); // status read
		`CHK(st, 8'h06) // active status
		therm = 1'b1;
		tick(6);
		`CHK({pump_en, drv_en, gate_rlow, outs}, 8'h20) // pump held off
		therm = 1'b0;
		tick(6);
		`CHK({pump_en, drv_en}, 2'b11) // recovers
		// Pump low must persist through the filter before latching.
		pump_low = 1'b1;
		tick(FLT - 8);
		`CHK(flag, 1'b0) // filtered
		tick(18);
		pump_low = 1'b0;
		`CHK({flag, drv_en, gate_rlow, outs}, 8'hA0) // latched off
		tick(50);
		xfer(8'h00, st); // read while latched
		`CHK(st, 8'h03) // flag held
		xfer(8'h80, st); // software reset
		`CHK(st, 8'h03) // flag still reported in that frame
		`CHK(flag, 1'b0) // cleared
		// The unused command code must leave the hold bit and controls alone.
		xfer(8'hC0, st); // ignored command
		`CHK(st, 8'h06) // drivers back on
		`CHK({active, drv_en}, 2'b11) // still held
		// Outputs commanded off before letting it sleep.
		xfer(8'h40, st); // release with outputs off
		`CHK({active, drv_en}, 2'b00) // released
		tick(AWK + 20);
		`CHK({analog_en, outs}, 6'h00) // standby
		test_done();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
